// >>> common/brg_if.sv
// Purpose: Link between transmitter control and baud rate generator
// Assumes: Single clock domain
// Notes: tick is a one-cycle enable pulse, high every cycle for a zero divisor
`timescale 1ns/100ps
interface brg_if;
  logic run;
  logic [7:0] divisor;
  logic tick;
  modport ctrl (output run, output divisor, input tick);
  modport gen (input run, input divisor, output tick);
endinterface : brg_if

// >>> common/usart_sync_pkg.sv
// Purpose: Shared constants for the synchronous master transmitter
// Assumes: APB register map, 32-bit words, one register per word
// Notes: Offsets are byte addresses on the APB bus
package usart_sync_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_TX_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_RX_STATUS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_BAUD_DIVISOR = 8'h08;
  localparam logic [7:0] OFS_HOLDING_BUFFER = 8'h0C;
  localparam logic [7:0] OFS_IRQ_FLAGS = 8'h10;
  localparam logic [7:0] OFS_IRQ_ENABLES = 8'h14;
  localparam logic [7:0] OFS_PIN_LEVELS = 8'h18;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TSC_MASTER_BIT = 7;
  localparam int TSC_NINTH_MODE_BIT = 6;
  localparam int TSC_TX_ENABLE_BIT = 5;
  localparam int TSC_SYNC_BIT = 4;
  localparam int TSC_SHIFTER_EMPTY_BIT = 1;
  localparam int TSC_NINTH_VALUE_BIT = 0;
  localparam int RSC_PORT_ENABLE_BIT = 7;
  localparam int RSC_SINGLE_RX_BIT = 5;
  localparam int RSC_CONT_RX_BIT = 4;
  localparam int IRQ_TX_EMPTY_BIT = 1;
  localparam int PIN_CLOCK_BIT = 0;
  localparam int PIN_DATA_BIT = 1;
  // ----------------------------------------------------------------
  // Widths, counts and reset values
  // ----------------------------------------------------------------
  localparam int DATA_WIDTH = 8;
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE = 4'h9;
  localparam logic [7:0] DIVISOR_RESET = 8'h00;
  localparam logic [2:0] SYNC_RESET = 3'h0;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  // ----------------------------------------------------------------
  // Transmitter states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SHIFT = 2'b10
  } tx_state_e;
endpackage : usart_sync_pkg

// >>> hw/baud_rate_generator.sv
// Purpose: Baud rate generator producing one tick per divisor+1 cycles
// Assumes: Divisor stable while running
// Notes: Held in reset while run is low
`timescale 1ns/100ps
module baud_rate_generator (
  input wire logic pclk,
  input wire logic presetn,
  brg_if.gen brg
);
  import usart_sync_pkg::*;

  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } brg_s;

  brg_s r;
  brg_s next_r;

  always_comb begin
    next_r = r;
    next_r.tick = 1'b0;
    if (!brg.run) begin
      // Reloading while idle gives a full first period
      next_r.cnt = brg.divisor;
    end else if (r.cnt == 8'h00) begin
      next_r.cnt = brg.divisor;
      next_r.tick = 1'b1;
    end else begin
      next_r.cnt = r.cnt - 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign brg.tick = r.tick;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // A zero divisor ticks every cycle by design
  tick_single_a: assert property (
    r.tick && (r.cnt != 8'h00) |=> !r.tick)
    else $error("baud tick lasted more than one cycle");
endmodule : baud_rate_generator

// >>> hw/usart_sync_master_transmitter.sv
// Purpose: Synchronous master transmit path with APB registers
// Assumes: Receive shift logic lives elsewhere and reports word done
// Notes: Zero-wait APB slave, read data registered in setup phase
`timescale 1ns/100ps

// Behaviour
// - Link is half-duplex; receive enable freezes transmission.
// - Sync mode bit 4 of transmit control selects clocked mode.
// - Port enable bit 7 of receive control hands pins to the port.
// - Master bit 7 of transmit control makes device drive clock.
// - Shifter loads only after last bit, at once from buffer.
// - Buffer move takes one cycle, without waiting for a baud tick; empty flag sets.
// - Empty flag sets only when an enabled shifter loads; only a buffer write clears.
// - Read-only shifter-empty flag, bit 1, polled by software.
// - Transmit enable bit 5 starts; nothing shifts until buffer loaded.
// - Bit goes out on clock rise, stable around clock fall.
// - Baud generator reset while all enables clear; runs on enable.
// - Write with empty shifter passes straight through; back to back.
// - Clearing transmit enable aborts, resets, releases data pin; clock pin too unless receive enabled.
// - Receive enable freezes, releases data pin, clock stays driven.
// - After single word received, clear it and resume driving data.
// - Ninth bit mode sends ninth value latched at shifter load.
// - Shift register is not software visible.
// - Clearing port enable or transmit enable resets transmit logic.
module usart_sync_master_transmitter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic single_word_received,
  output logic receive_mode,
  input wire logic shift_timing_pin_in,
  output logic shift_timing_pin_out,
  output logic shift_timing_pin_oe,
  input wire logic serial_data_pin_in,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe
);
  import usart_sync_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic master_source_select;
    logic ninth_bit_mode_select;
    logic transmit_enable;
    logic sync_mode;
    logic ninth_bit_value;
    logic serial_port_enable;
    logic single_receive_enable;
    logic continuous_receive_enable;
    logic transmit_buffer_irq_enable;
    logic [7:0] baud_divisor_register;
    logic [7:0] transmit_holding_buffer;
    logic holding_full;
    logic [8:0] transmit_shift_register;
    logic [3:0] bits_left;
    tx_state_e state;
    logic shift_clock;
    logic data_out;
    logic clock_oe;
    logic data_oe;
    logic [31:0] read_data;
    logic [2:0] clock_sync;
    logic [2:0] data_sync;
    logic clock_level;
    logic data_level;
  } core_s;

  core_s r;
  core_s next_r;
  brg_if brg ();

  logic apb_write;
  logic apb_setup_read;
  logic tx_on;
  logic rx_on;
  logic load;
  logic tick;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFS_TX_STATUS_CONTROL) || (a == OFS_RX_STATUS_CONTROL) ||
             (a == OFS_BAUD_DIVISOR) || (a == OFS_HOLDING_BUFFER) ||
             (a == OFS_IRQ_FLAGS) || (a == OFS_IRQ_ENABLES) ||
             (a == OFS_PIN_LEVELS);
  endfunction : mapped

  function automatic logic [31:0] read_word(input core_s s,
                                            input logic [7:0] a);
    logic [31:0] w;
    w = WORD_ZERO;
    unique case (a)
      OFS_TX_STATUS_CONTROL: begin
        w[TSC_MASTER_BIT] = s.master_source_select;
        w[TSC_NINTH_MODE_BIT] = s.ninth_bit_mode_select;
        w[TSC_TX_ENABLE_BIT] = s.transmit_enable;
        w[TSC_SYNC_BIT] = s.sync_mode;
        w[TSC_SHIFTER_EMPTY_BIT] = (s.state == TX_IDLE);
        w[TSC_NINTH_VALUE_BIT] = s.ninth_bit_value;
      end
      OFS_RX_STATUS_CONTROL: begin
        w[RSC_PORT_ENABLE_BIT] = s.serial_port_enable;
        w[RSC_SINGLE_RX_BIT] = s.single_receive_enable;
        w[RSC_CONT_RX_BIT] = s.continuous_receive_enable;
      end
      OFS_BAUD_DIVISOR: w[7:0] = s.baud_divisor_register;
      // Shift register has no address; only the buffer reads back
      OFS_HOLDING_BUFFER: w[7:0] = s.transmit_holding_buffer;
      OFS_IRQ_FLAGS: w[IRQ_TX_EMPTY_BIT] = !s.holding_full;
      OFS_IRQ_ENABLES: w[IRQ_TX_EMPTY_BIT] = s.transmit_buffer_irq_enable;
      OFS_PIN_LEVELS: begin
        w[PIN_CLOCK_BIT] = s.clock_level;
        w[PIN_DATA_BIT] = s.data_level;
      end
      default: w = WORD_ZERO;
    endcase
    return w;
  endfunction : read_word

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  assign apb_write = psel && penable && pwrite && mapped(paddr);
  assign apb_setup_read = psel && !penable && !pwrite;
  assign tx_on = r.serial_port_enable && r.sync_mode &&
                 r.master_source_select && r.transmit_enable;
  assign rx_on = r.single_receive_enable || r.continuous_receive_enable;
  assign tick = brg.tick;
  // Buffer moves into an empty shifter in one cycle
  assign load = tx_on && !rx_on && (r.state == TX_IDLE) &&
                r.holding_full;

  always_comb begin
    next_r = r;
    // Pin inputs: act only when second and third stage agree
    next_r.clock_sync = {r.clock_sync[1:0], shift_timing_pin_in};
    next_r.data_sync = {r.data_sync[1:0], serial_data_pin_in};
    if (r.clock_sync[1] == r.clock_sync[2]) begin
      next_r.clock_level = r.clock_sync[2];
    end
    if (r.data_sync[1] == r.data_sync[2]) begin
      next_r.data_level = r.data_sync[2];
    end
    if (apb_setup_read) begin
      next_r.read_data = read_word(r, paddr);
    end
    // Hardware clear first so a software write in the same cycle rules
    if (single_word_received && r.single_receive_enable) begin
      next_r.single_receive_enable = 1'b0;
    end
    // ----------------------------------------------------------------
    // Transmitter
    // ----------------------------------------------------------------
    unique case (r.state)
      TX_IDLE: begin
        if (load) begin
          next_r.transmit_shift_register = {r.ninth_bit_value,
                                            r.transmit_holding_buffer};
          next_r.bits_left = r.ninth_bit_mode_select ? BITS_NINE :
                             BITS_EIGHT;
          next_r.state = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        // Receive owns the line: freeze without losing the word
        if (tick && !rx_on) begin
          if (!r.shift_clock) begin
            next_r.shift_clock = 1'b1;
            next_r.data_out = r.transmit_shift_register[0];
            next_r.transmit_shift_register = {1'b0,
              r.transmit_shift_register[8:1]};
            next_r.bits_left = r.bits_left - 4'h1;
          end else begin
            next_r.shift_clock = 1'b0;
            if (r.bits_left == 4'h0) begin
              next_r.state = TX_IDLE;
            end
          end
        end
      end
      default: next_r.state = TX_IDLE;
    endcase
    // Holding buffer stays intact; only shifting logic is cleared
    if (!r.serial_port_enable || !r.transmit_enable) begin
      next_r.state = TX_IDLE;
      next_r.shift_clock = 1'b0;
      next_r.bits_left = 4'h0;
    end
    // New data wins over the load that empties the buffer
    next_r.holding_full = (r.holding_full && !load);
    if (apb_write) begin
      unique case (paddr)
        OFS_TX_STATUS_CONTROL: begin
          next_r.master_source_select = pwdata[TSC_MASTER_BIT];
          next_r.ninth_bit_mode_select = pwdata[TSC_NINTH_MODE_BIT];
          next_r.transmit_enable = pwdata[TSC_TX_ENABLE_BIT];
          next_r.sync_mode = pwdata[TSC_SYNC_BIT];
          next_r.ninth_bit_value = pwdata[TSC_NINTH_VALUE_BIT];
        end
        OFS_RX_STATUS_CONTROL: begin
          next_r.serial_port_enable = pwdata[RSC_PORT_ENABLE_BIT];
          next_r.single_receive_enable = pwdata[RSC_SINGLE_RX_BIT];
          next_r.continuous_receive_enable = pwdata[RSC_CONT_RX_BIT];
        end
        OFS_BAUD_DIVISOR: next_r.baud_divisor_register = pwdata[7:0];
        OFS_HOLDING_BUFFER: begin
          next_r.transmit_holding_buffer = pwdata[7:0];
          next_r.holding_full = 1'b1;
        end
        OFS_IRQ_ENABLES: begin
          next_r.transmit_buffer_irq_enable = pwdata[IRQ_TX_EMPTY_BIT];
        end
        default: next_r.holding_full = next_r.holding_full;
      endcase
    end
    // ----------------------------------------------------------------
    // Pin ownership
    // ----------------------------------------------------------------
    next_r.clock_oe = r.serial_port_enable && r.sync_mode &&
                      r.master_source_select &&
                      (r.transmit_enable || rx_on);
    next_r.data_oe = tx_on && !rx_on;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{state: TX_IDLE, baud_divisor_register: DIVISOR_RESET,
             clock_sync: SYNC_RESET, data_sync: SYNC_RESET,
             read_data: WORD_ZERO, transmit_shift_register: 9'h000,
             transmit_holding_buffer: 8'h00, bits_left: 4'h0,
             default: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Baud rate generator
  // ----------------------------------------------------------------
  // Held in reset until the port and some direction are enabled
  assign brg.run = r.serial_port_enable &&
                   (r.transmit_enable || rx_on);
  assign brg.divisor = r.baud_divisor_register;

  baud_rate_generator u_brg (
    .pclk(pclk),
    .presetn(presetn),
    .brg(brg)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = r.read_data;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);
  assign receive_mode = r.serial_port_enable && rx_on;
  assign shift_timing_pin_out = r.shift_clock;
  assign shift_timing_pin_oe = r.clock_oe;
  assign serial_data_pin_out = r.data_out;
  assign serial_data_pin_oe = r.data_oe;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence buffer_write_s;
    apb_write && (paddr == OFS_HOLDING_BUFFER);
  endsequence

  sequence idle_and_ready_s;
    tx_on && !rx_on && (r.state == TX_IDLE) && !r.holding_full;
  endsequence

  flag_clear_write_a: assert property (
    buffer_write_s |=> r.holding_full)
    else $error("buffer write did not clear empty flag");
  direct_pass_a: assert property (
    idle_and_ready_s ##0 buffer_write_s |=>
    load ##1 (r.state == TX_SHIFT) && !r.holding_full)
    else $error("write to idle shifter did not pass straight through");
  brg_hold_a: assert property (!brg.run |=> !brg.tick)
    else $error("baud generator ran while all enables clear");
  // Receive alone keeps the clock pin, so it is excluded here
  tx_disable_release_a: assert property (
    !r.transmit_enable && !rx_on |=>
    !serial_data_pin_oe && !shift_timing_pin_oe)
    else $error("pins still driven after transmit disable");
  rx_abort_pins_a: assert property (
    rx_on && r.serial_port_enable && r.sync_mode &&
    r.master_source_select |=> !serial_data_pin_oe && shift_timing_pin_oe)
    else $error("receive enable did not release only the data pin");
  rx_freeze_a: assert property (
    rx_on && $stable(rx_on) |=> $stable(r.transmit_shift_register))
    else $error("shifter moved while receiving");
  rise_shift_bit_a: assert property (
    $rose(r.shift_clock) |->
    r.data_out == $past(r.transmit_shift_register[0]))
    else $error("data bit not taken from shifter lsb on clock rise");
  load_count_a: assert property (
    load |=> r.bits_left == ($past(r.ninth_bit_mode_select) ? BITS_NINE :
    BITS_EIGHT))
    else $error("wrong bit count loaded");
  disable_reset_a: assert property (
    !r.serial_port_enable |=> (r.state == TX_IDLE) && !r.shift_clock)
    else $error("transmitter not reset by port disable");
  single_rx_clear_a: assert property (
    single_word_received && r.single_receive_enable && !apb_write |=>
    !r.single_receive_enable)
    else $error("single receive enable not cleared after word");
  // Ninth value is the one standing in the cycle of the load
  load_word_a: assert property (
    load |=> r.transmit_shift_register ==
    {$past(r.ninth_bit_value), $past(r.transmit_holding_buffer)})
    else $error("shifter loaded with wrong word");
  load_empties_a: assert property (
    load && !(apb_write && (paddr == OFS_HOLDING_BUFFER)) |=>
    !r.holding_full)
    else $error("buffer not empty after move to shifter");
  idle_clock_low_a: assert property (
    (r.state == TX_IDLE) |-> !r.shift_clock)
    else $error("shift clock toggled with no word loaded");

  sequence last_fall_s;
    tx_on && !rx_on && tick && (r.state == TX_SHIFT) && r.shift_clock &&
    (r.bits_left == 4'h0);
  endsequence

  word_end_a: assert property (
    last_fall_s |=> (r.state == TX_IDLE) && !r.shift_clock)
    else $error("shifter not idle after last bit");
  resume_drive_a: assert property (
    $fell(rx_on) && tx_on |=> serial_data_pin_oe)
    else $error("data pin not driven again after reception");
endmodule : usart_sync_master_transmitter

// >>> tb/sync_slave_model.sv
// Purpose: Far-side synchronous slave that records the received bits
// Assumes: Bits are taken on the falling shift clock edge
// Notes: Drives the data line only while the bench asks it to
`timescale 1ns/100ps
module sync_slave_model (
  input wire logic ck_line,
  input wire logic dt_line,
  input wire logic talk,
  output logic dt_out,
  output logic dt_oe
);
  // ----------------------------------------------------------------
  // Capture and answer
  // ----------------------------------------------------------------
  logic bits[$];
  initial dt_out = 1'b0;
  assign dt_oe = talk;
  // Sample mid-bit, where the sender holds the data stable
  always @(negedge ck_line) begin
    bits.push_back(dt_line);
  end
  // New level each clock so a stale value never passes for data
  always @(posedge ck_line) begin
    dt_out <= ~dt_out;
  end
endmodule : sync_slave_model

// >>> tb/tb.sv
// Purpose: Self-checking bench for the synchronous master transmitter
// Assumes: Zero-wait APB slave, slave model on the far side
// Notes: Clock line has a pull-down, data line a pull-up
`timescale 1ns/100ps
module tb;
  import usart_sync_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, err, talk;
  logic single_word_received, pready, pslverr, receive_mode;
  logic [7:0] paddr, div;
  logic [31:0] pwdata, prdata, rd, base;
  logic ck_out, ck_oe, dt_out, dt_oe, m_out, m_oe;
  logic expq[$];
  wire logic ck_line;
  wire logic dt_line;
  int fail_count, checks_done, cycles;
  assign ck_line = ck_oe ? ck_out : 1'b0;
  assign dt_line = dt_oe ? dt_out : (m_oe ? m_out : 1'b1);

  usart_sync_master_transmitter i_usart_sync_master_transmitter (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .single_word_received(single_word_received),
    .receive_mode(receive_mode), .shift_timing_pin_in(ck_line),
    .shift_timing_pin_out(ck_out), .shift_timing_pin_oe(ck_oe),
    .serial_data_pin_in(dt_line), .serial_data_pin_out(dt_out),
    .serial_data_pin_oe(dt_oe));
  sync_slave_model i_sync_slave_model (.ck_line(ck_line),
    .dt_line(dt_line), .talk(talk), .dt_out(m_out), .dt_oe(m_oe));

  // ----------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------------------------------
  initial pclk = 1'b0;
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic conclude();
    if (fail_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Relies on the cycle ceiling if the bit never sets
  task automatic poll(input logic [7:0] a, input int b);
    rd = WORD_ZERO;
    while (rd[b] !== 1'b1) apb(1'b0, a, WORD_ZERO);
  endtask : poll

  // Bits leave lsb first, ninth value last
  function automatic logic [8:0] frame(input logic [7:0] w,
                                       input logic nv);
    return {nv, w};
  endfunction : frame

  task automatic send(input logic [7:0] w, input logic nine,
                      input logic nv);
    logic [8:0] f;
    poll(OFS_IRQ_FLAGS, IRQ_TX_EMPTY_BIT);
    if (nine) begin
      apb(1'b1, OFS_TX_STATUS_CONTROL,
          base | 32'h0000_0040 | 32'(nv));
    end
    apb(1'b1, OFS_HOLDING_BUFFER, {24'h0, w});
    f = frame(w, nv);
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      expq.push_back(f[i]);
    end
  endtask : send

  task automatic drain_compare();
    poll(OFS_IRQ_FLAGS, IRQ_TX_EMPTY_BIT);
    poll(OFS_TX_STATUS_CONTROL, TSC_SHIFTER_EMPTY_BIT);
    check(32'(i_sync_slave_model.bits.size()),
          32'(expq.size()));
    foreach (expq[i]) begin
      check(32'(i_sync_slave_model.bits[i]), 32'(expq[i]));
    end
    i_sync_slave_model.bits.delete();
    expq.delete();
  endtask : drain_compare

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, talk, single_word_received} = '0;
    paddr = 8'h00;
    pwdata = WORD_ZERO;
    void'($urandom(63175));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // Unknown clock line before reset can fake a falling edge
    i_sync_slave_model.bits.delete();
    apb(1'b0, OFS_TX_STATUS_CONTROL, WORD_ZERO);
    check(rd, 32'h0000_0002);
    apb(1'b1, OFS_IRQ_ENABLES, 32'h0000_0002);
    apb(1'b1, OFS_IRQ_FLAGS, WORD_ZERO);
    apb(1'b0, OFS_IRQ_FLAGS, WORD_ZERO);
    check(rd, 32'h0000_0002);
    apb(1'b0, OFS_IRQ_ENABLES, WORD_ZERO);
    check(rd, 32'h0000_0002);
    apb(1'b0, 8'h1C, WORD_ZERO);
    check({rd[30:0], err}, 32'h0000_0001);
    div = 8'($urandom_range(3, 1));
    apb(1'b1, OFS_BAUD_DIVISOR, {24'h0, div});
    base = 32'h0000_0090; // Master and clocked mode
    apb(1'b1, OFS_TX_STATUS_CONTROL, base);
    apb(1'b1, OFS_RX_STATUS_CONTROL, 32'h0000_0080);
    // Buffer first, enable later: nothing may shift meanwhile
    send(8'($urandom), 1'b0, 1'b0);
    apb(1'b0, OFS_IRQ_FLAGS, WORD_ZERO);
    check(32'(rd[1]), 32'h0);
    repeat (20) @(posedge pclk);
    check(32'(i_sync_slave_model.bits.size()), 32'h0);
    check(32'(ck_out), 32'h0);
    base = 32'h0000_00B0;
    apb(1'b1, OFS_TX_STATUS_CONTROL, base);
    apb(1'b0, OFS_TX_STATUS_CONTROL, WORD_ZERO);
    check(32'(rd[1]), 32'h0);
    for (int k = 0; k < 6; k++) begin
      if (k == 3) drain_compare();
      send(8'($urandom), k > 2, 1'($urandom));
    end
    drain_compare();
    base = 32'h0000_00B0;
    apb(1'b1, OFS_TX_STATUS_CONTROL, base);
    // Receive enables cut in mid-word
    send(8'h5A, 1'b0, 1'b0);
    repeat (6) @(posedge pclk);
    apb(1'b1, OFS_RX_STATUS_CONTROL, 32'h0000_0090);
    talk <= 1'b1;
    repeat (2) @(posedge pclk);
    check({29'h0, dt_oe, ck_oe, receive_mode}, 32'h3);
    apb(1'b1, OFS_RX_STATUS_CONTROL, 32'h0000_00A0);
    single_word_received <= 1'b1;
    @(posedge pclk);
    single_word_received <= 1'b0;
    talk <= 1'b0;
    repeat (2) @(posedge pclk);
    check(32'(dt_oe), 32'h1);
    apb(1'b0, OFS_RX_STATUS_CONTROL, WORD_ZERO);
    check(rd, 32'h0000_0080);
    apb(1'b1, OFS_TX_STATUS_CONTROL, 32'h0000_0090);
    repeat (2) @(posedge pclk);
    check({30'h0, dt_oe, ck_oe}, 32'h0);
    // Port disable mid-word, then a clean restart
    apb(1'b1, OFS_TX_STATUS_CONTROL, base);
    send(8'hC3, 1'b0, 1'b0);
    repeat (6) @(posedge pclk);
    apb(1'b1, OFS_RX_STATUS_CONTROL, WORD_ZERO);
    repeat (2) @(posedge pclk);
    check({30'h0, dt_oe, ck_oe}, 32'h0);
    apb(1'b0, OFS_TX_STATUS_CONTROL, WORD_ZERO);
    check(32'(rd[1]), 32'h1);
    i_sync_slave_model.bits.delete();
    expq.delete();
    apb(1'b1, OFS_RX_STATUS_CONTROL, 32'h0000_0080);
    send(8'($urandom), 1'b0, 1'b0);
    apb(1'b0, OFS_IRQ_FLAGS, WORD_ZERO);
    check(32'(rd[1]), 32'h1);
    drain_compare();
    // Without the master bit the clock pin stays released
    apb(1'b1, OFS_TX_STATUS_CONTROL, 32'h0000_0030);
    repeat (2) @(posedge pclk);
    check(32'(ck_oe), 32'h0);
    // Pin levels pass four flops before they read back
    repeat (6) @(posedge pclk);
    apb(1'b0, OFS_PIN_LEVELS, WORD_ZERO);
    check(rd, 32'h0000_0002);
    conclude();
  end
endmodule : tb
